// File: pkg/pecu_consts.svh
// Constants of the performance event counter unit: map, fields, codes.
// Assumes inclusion by bare name; definitions only.
`ifndef PECU_CONSTS_SVH
`define PECU_CONSTS_SVH

// ****************************************
// Sizes
// ****************************************
`define PECU_CTR_W      48
`define PECU_NUM_GP     2
`define PECU_NUM_FX     3
`define PECU_NUM_CTR    5
`define PECU_SYNC_W     3

// ****************************************
// Register addresses
// ****************************************
`define PECU_A_FIX_CTL  12'h38d
`define PECU_A_GLB_EN   12'h380
`define PECU_A_GLB_ST   12'h381
`define PECU_A_GLB_CLR  12'h382
`define PECU_A_DBG      12'h383
`define PECU_A_PRECISE  12'h384
`define PECU_A_ENUM_EV  12'h385
`define PECU_A_ENUM_FX  12'h386
`define PECU_A_GP_CTR   12'h0c1
`define PECU_A_GP_SEL   12'h186
`define PECU_A_FX_CTR   12'h309

// ****************************************
// Field positions
// ****************************************
`define PECU_ST_FX_LO   32
`define PECU_ST_SMP     62
`define PECU_ST_CHG     63
`define PECU_DBG_FRZ_BR 11
`define PECU_DBG_FRZ_CT 12
`define PECU_SEL_USR    16
`define PECU_SEL_OS     17
`define PECU_SEL_INT    20
`define PECU_SEL_EN     22
`define PECU_FXC_RING0  0
`define PECU_FXC_RING3  1
`define PECU_FXC_IRQ    3
`define PECU_FXC_W      4

// ****************************************
// Event codes {qualifier, event select} and enumeration
// ****************************************
`define PECU_EV_CORE    16'h003c
`define PECU_EV_INSTR   16'h00c0
`define PECU_EV_REF     16'h013c
`define PECU_EV_LLCREF  16'h4f2e
`define PECU_EV_LLCMISS 16'h412e
`define PECU_EV_BR      16'h00c4
`define PECU_EV_BRMISS  16'h00c5
`define PECU_EV_UNAVAIL 7'h00
`define PECU_FX_NUM_ENC 5'h03
`define PECU_FX_W_ENC   8'h30

`endif

// File: pkg/pecu_pkg.sv
// Types of the performance event counter unit.
// Assumes the constants header is on the include path.
`default_nettype none
`include "pecu_consts.svh"

package pecu_pkg;

  // State of the top block, counters apart
  typedef struct packed {
    logic [11:0]                fix_ctl;   // Three 4-bit controls
    logic [`PECU_NUM_GP-1:0][31:0] evsel;  // Event selects
    logic [`PECU_NUM_CTR-1:0]   glob_en;   // Global enables
    logic [`PECU_NUM_CTR-1:0]   ovf;       // Overflow status
    logic                       smp_flag;  // Sample buffer flag
    logic                       chg_flag;  // Condition changed
    logic [`PECU_NUM_GP-1:0]    precise;   // Precise sampling on
    logic                       frz_br;    // Freeze records on irq
    logic                       frz_ct;    // Freeze counters on irq
    logic [63:0]                rdata;     // Read answer
    logic                       rvalid;    // Read answer strobe
    logic                       irq;       // Interrupt pulse
    logic                       smp_req;   // Sample store pulse
    logic                       br_frz;    // Record freeze pulse
    logic [`PECU_SYNC_W-1:0]    stop_sync; // Stop clock pin sync
    logic [`PECU_SYNC_W-1:0]    ref_sync;  // Reference tick sync
  } pecu_state_t;

  // State of one counter
  typedef struct packed {
    logic [`PECU_CTR_W-1:0] value;
  } pecu_cnt_t;

endpackage : pecu_pkg
`default_nettype wire

// File: design/pecu_counter.sv
// One counter of the unit: write, increment and wrap detection.
// Assumes the caller prepares the written value at full width.
`timescale 1ns/1ps
`default_nettype none
`include "pecu_consts.svh"

module pecu_counter (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   inc,
  input  wire logic                   wr_en,
  input  wire logic [`PECU_CTR_W-1:0] wr_val,
  output logic      [`PECU_CTR_W-1:0] value,
  output logic                        wrap
);

  pecu_pkg::pecu_cnt_t q_ff;   // Registered count
  pecu_pkg::pecu_cnt_t nxt_q;  // Next count

  // ****************************************
  // Next count
  // ****************************************
  // A write wins over an event in the same cycle, so software
  // always sees exactly the value it loaded.
  always_comb begin
    nxt_q = q_ff;
    if (wr_en) begin
      nxt_q.value = wr_val;
    end else if (inc) begin
      nxt_q.value = q_ff.value + `PECU_CTR_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign value = q_ff.value;
  assign wrap  = inc & ~wr_en & (&q_ff.value);

endmodule : pecu_counter
`default_nettype wire

// File: design/pecu_top.sv
// Performance event counter unit: two general and three fixed counters,
// global enable, overflow status and clear, reached by register port.
// Assumes event inputs are on clk except the stop clock pin and the
// reference tick, which is much slower than clk.
`timescale 1ns/1ps
`default_nettype none
`include "pecu_consts.svh"

// Functional notes
// - Enumeration bits 0-6 mark unavailable events
// - Core cycles count only while core runs
// - Instruction counts once at last micro-op
// - No instruction count on VM exit
// - Reference cycles count while core runs
// - Count last level cache references
// - Count last level cache misses
// - Count retired branch instructions
// - Count retired mispredicted branches
// - Fixed counters configured by one control register
// - Two-bit privilege enable per fixed counter
// - Fourth control bit enables overflow interrupt
// - Count only when global and local enabled
// - Status bits 0,1,32-34 flag overflows
// - Precise overflow: interrupt, store, flag buffer
// - Condition-changed bit on control state change
// - One clear write clears selected overflow bits
// - Enumerate fixed counter count and width
// - Debug bits 11, 12 freeze on interrupt
// - General counter needs select enable bit 22
// - General counter write sign-extends from bit 31
module pecu_top (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        msr_wr,         // Register write strobe
  input  wire logic        msr_rd,         // Register read strobe
  input  wire logic [11:0] msr_addr,       // Register address
  input  wire logic [63:0] msr_wdata,      // Write data
  output logic      [63:0] msr_rdata,      // Read data
  output logic             msr_rvalid,     // Read data valid
  input  wire logic        cpl0,           // Core at ring 0
  input  wire logic        cstate_idle,    // Low power idle state
  input  wire logic        halt,           // Halted
  input  wire logic        stop_clock_input, // Pin, asynchronous
  input  wire logic        thermal_throttle, // Throttled
  input  wire logic        freq_switch,    // Frequency switch phase
  input  wire logic        ref_tick,       // Reference clock level
  input  wire logic        retire_last_uop, // Last micro-op retired
  input  wire logic        retire_fault,   // Fault before last uop
  input  wire logic        vm_exit,        // VM exit condition
  input  wire logic        last_level_cache_ref,  // Cache reference
  input  wire logic        last_level_cache_miss, // Cache miss
  input  wire logic        branch_retire,  // Branch retired
  input  wire logic        branch_mispredict, // Mispredict retired
  output logic             counter_overflow_interrupt, // To local irq
  output logic             sample_store_req,  // Store sample records
  output logic             branch_record_freeze // Freeze records
);

  // ****************************************
  // State and event nets
  // ****************************************
  pecu_pkg::pecu_state_t q_ff;   // Registered state
  pecu_pkg::pecu_state_t nxt_q;  // Next state

  logic [`PECU_NUM_CTR-1:0]                  inc;   // Per counter
  logic [`PECU_NUM_CTR-1:0]                  wr;    // Counter write
  logic [`PECU_NUM_CTR-1:0][`PECU_CTR_W-1:0] wval;  // Written value
  logic [`PECU_NUM_CTR-1:0][`PECU_CTR_W-1:0] cnt;   // Counter values
  logic [`PECU_NUM_CTR-1:0]                  wrap;  // Wrap pulses
  logic [6:0]                                evs;   // Event bits
  logic                                      core_run;
  logic                                      instr_ev;
  logic                                      ref_ev;
  logic [`PECU_NUM_CTR-1:0]                  clr;   // Clear mask
  logic                                      clr_smp;
  logic                                      clr_chg;

  // Map a {qualifier, event} code to one of the seven events
  function automatic logic gp_hit(input logic [15:0] code,
                                  input logic [6:0]  ev);
    case (code)
      `PECU_EV_CORE:    gp_hit = ev[0];
      `PECU_EV_INSTR:   gp_hit = ev[1];
      `PECU_EV_REF:     gp_hit = ev[2];
      `PECU_EV_LLCREF:  gp_hit = ev[3];
      `PECU_EV_LLCMISS: gp_hit = ev[4];
      `PECU_EV_BR:      gp_hit = ev[5];
      `PECU_EV_BRMISS:  gp_hit = ev[6];
      default:          gp_hit = 1'b0;
    endcase
  endfunction : gp_hit

  // ****************************************
  // Event conditioning
  // ****************************************
  // core cycles gated
  assign core_run = ~(cstate_idle | halt | q_ff.stop_sync[2] |
                      thermal_throttle | freq_switch);
  // vm exit suppressed, interrupts and traps still counted
  assign instr_ev = retire_last_uop & ~retire_fault & ~vm_exit;
  assign ref_ev   = q_ff.ref_sync[1] & ~q_ff.ref_sync[2] & core_run;
  assign evs = {branch_mispredict, branch_retire, last_level_cache_miss,
                last_level_cache_ref, ref_ev, instr_ev, core_run} &
               ~`PECU_EV_UNAVAIL;

  // ****************************************
  // Counter enables and writes
  // ****************************************
  always_comb begin
    inc  = '0;
    wr   = '0;
    wval = '0;
    for (int i = 0; i < `PECU_NUM_GP; i++) begin
      // global AND select enable AND privilege
      inc[i] = q_ff.glob_en[i] & q_ff.evsel[i][`PECU_SEL_EN] &
               ((q_ff.evsel[i][`PECU_SEL_OS] & cpl0) |
                (q_ff.evsel[i][`PECU_SEL_USR] & ~cpl0)) &
               gp_hit(q_ff.evsel[i][15:0], evs);
      wr[i]  = msr_wr & (msr_addr == `PECU_A_GP_CTR + 12'(i));
      wval[i] = {{(`PECU_CTR_W-32){msr_wdata[31]}}, msr_wdata[31:0]};
    end
    for (int j = 0; j < `PECU_NUM_FX; j++) begin
      // ring 0 and ring above 0 enables
      inc[`PECU_NUM_GP+j] = q_ff.glob_en[`PECU_NUM_GP+j] &
        ((q_ff.fix_ctl[`PECU_FXC_W*j+`PECU_FXC_RING0] & cpl0) |
         (q_ff.fix_ctl[`PECU_FXC_W*j+`PECU_FXC_RING3] & ~cpl0)) &
        ((j == 0) ? evs[1] : (j == 1) ? evs[0] : evs[2]);
      wr[`PECU_NUM_GP+j] = msr_wr &
        (msr_addr == `PECU_A_FX_CTR + 12'(j));
      // bits above the width are dropped
      wval[`PECU_NUM_GP+j] = msr_wdata[`PECU_CTR_W-1:0];
    end
  end

  // ****************************************
  // Counters
  // ****************************************
  for (genvar g = 0; g < `PECU_NUM_CTR; g++) begin : g_ctr
    pecu_counter u_ctr (
      .clk    (clk),
      .reset  (reset),
      .inc    (inc[g]),
      .wr_en  (wr[g]),
      .wr_val (wval[g]),
      .value  (cnt[g]),
      .wrap   (wrap[g])
    );
  end

  assign clr = (msr_wr && msr_addr == `PECU_A_GLB_CLR) ?
               {msr_wdata[`PECU_ST_FX_LO+2:`PECU_ST_FX_LO],
                msr_wdata[1:0]} : '0;
  assign clr_smp = msr_wr && msr_addr == `PECU_A_GLB_CLR &&
                   msr_wdata[`PECU_ST_SMP];
  assign clr_chg = msr_wr && msr_addr == `PECU_A_GLB_CLR &&
                   msr_wdata[`PECU_ST_CHG];

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [`PECU_NUM_CTR-1:0] set;
    logic [`PECU_NUM_CTR-1:0] pclr;
    logic                     smp;
    logic                     irq;
    logic                     chg;
    set   = '0;
    pclr  = '0;
    smp   = 1'b0;
    irq   = 1'b0;
    chg   = 1'b0;
    nxt_q = q_ff;
    // Stop pin passes three flops before use, reference tick two and three
    nxt_q.stop_sync = {q_ff.stop_sync[1:0], stop_clock_input};
    nxt_q.ref_sync  = {q_ff.ref_sync[1:0], ref_tick};
    for (int i = 0; i < `PECU_NUM_CTR; i++) begin
      if (wrap[i]) begin
        if (i < `PECU_NUM_GP && q_ff.precise[i]) begin
          pclr[i] = 1'b1;
          smp     = 1'b1;
          irq     = 1'b1;
        end else begin
          set[i] = 1'b1;
          if (i < `PECU_NUM_GP) begin
            irq = irq | q_ff.evsel[i][`PECU_SEL_INT];
          end else begin
            irq = irq | q_ff.fix_ctl[`PECU_FXC_W*(i-`PECU_NUM_GP) +
                                     `PECU_FXC_IRQ];
          end
        end
      end
    end
    // Control writes; any change except to the debug bits marks the condition bit
    if (msr_wr) begin
      case (msr_addr)
        `PECU_A_FIX_CTL: begin
          nxt_q.fix_ctl = msr_wdata[11:0];
          chg = nxt_q.fix_ctl != q_ff.fix_ctl;
        end
        `PECU_A_GLB_EN: begin
          nxt_q.glob_en = {msr_wdata[`PECU_ST_FX_LO+2:`PECU_ST_FX_LO],
                           msr_wdata[1:0]};
          chg = nxt_q.glob_en != q_ff.glob_en;
        end
        `PECU_A_GP_SEL: begin
          nxt_q.evsel[0] = msr_wdata[31:0];
          chg = nxt_q.evsel[0] != q_ff.evsel[0];
        end
        `PECU_A_GP_SEL + 12'h001: begin
          nxt_q.evsel[1] = msr_wdata[31:0];
          chg = nxt_q.evsel[1] != q_ff.evsel[1];
        end
        `PECU_A_PRECISE: begin
          nxt_q.precise = msr_wdata[`PECU_NUM_GP-1:0];
          chg = nxt_q.precise != q_ff.precise;
        end
        `PECU_A_DBG: begin
          nxt_q.frz_br = msr_wdata[`PECU_DBG_FRZ_BR];
          nxt_q.frz_ct = msr_wdata[`PECU_DBG_FRZ_CT];
        end
        default: begin
          chg = 1'b0;
        end
      endcase
    end
    // freezing counters drops all global enables
    if (irq && q_ff.frz_ct) begin
      nxt_q.glob_en = '0;
    end
    // clear, but a new overflow wins
    nxt_q.ovf      = (q_ff.ovf & ~clr & ~pclr) | set;
    // buffer flag set, set wins over clear
    nxt_q.smp_flag = (q_ff.smp_flag & ~clr_smp) | smp;
    nxt_q.chg_flag = (q_ff.chg_flag & ~clr_chg) | chg;
    nxt_q.irq      = irq;
    nxt_q.smp_req  = smp;
    nxt_q.br_frz   = irq & q_ff.frz_br;
    // Register reads; unmapped and write-only read as zero
    nxt_q.rvalid = msr_rd;
    nxt_q.rdata  = '0;
    if (msr_rd) begin
      case (msr_addr)
        `PECU_A_FIX_CTL: nxt_q.rdata[11:0] = q_ff.fix_ctl;
        `PECU_A_GLB_EN: begin
          nxt_q.rdata[1:0] = q_ff.glob_en[1:0];
          nxt_q.rdata[`PECU_ST_FX_LO+2:`PECU_ST_FX_LO] =
            q_ff.glob_en[4:2];
        end
        `PECU_A_GLB_ST: begin
          nxt_q.rdata[1:0] = q_ff.ovf[1:0];
          nxt_q.rdata[`PECU_ST_FX_LO+2:`PECU_ST_FX_LO] = q_ff.ovf[4:2];
          nxt_q.rdata[`PECU_ST_SMP] = q_ff.smp_flag;
          nxt_q.rdata[`PECU_ST_CHG] = q_ff.chg_flag;
        end
        `PECU_A_DBG: begin
          nxt_q.rdata[`PECU_DBG_FRZ_BR] = q_ff.frz_br;
          nxt_q.rdata[`PECU_DBG_FRZ_CT] = q_ff.frz_ct;
        end
        `PECU_A_PRECISE: nxt_q.rdata[1:0] = q_ff.precise;
        `PECU_A_ENUM_EV: nxt_q.rdata[6:0] = `PECU_EV_UNAVAIL;
        `PECU_A_ENUM_FX: nxt_q.rdata[12:0] = {`PECU_FX_W_ENC,
                                              `PECU_FX_NUM_ENC};
        `PECU_A_GP_SEL:           nxt_q.rdata[31:0] = q_ff.evsel[0];
        `PECU_A_GP_SEL + 12'h001: nxt_q.rdata[31:0] = q_ff.evsel[1];
        `PECU_A_GP_CTR:           nxt_q.rdata[47:0] = cnt[0];
        `PECU_A_GP_CTR + 12'h001: nxt_q.rdata[47:0] = cnt[1];
        `PECU_A_FX_CTR:           nxt_q.rdata[47:0] = cnt[2];
        `PECU_A_FX_CTR + 12'h001: nxt_q.rdata[47:0] = cnt[3];
        `PECU_A_FX_CTR + 12'h002: nxt_q.rdata[47:0] = cnt[4];
        default:                  nxt_q.rdata = '0;
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Every output straight from a flop
  assign msr_rdata                  = q_ff.rdata;
  assign msr_rvalid                 = q_ff.rvalid;
  assign counter_overflow_interrupt = q_ff.irq;
  assign sample_store_req           = q_ff.smp_req;
  assign branch_record_freeze       = q_ff.br_frz;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence precise_wrap_s;
    wrap[0] && q_ff.precise[0];
  endsequence
  sequence precise_effect_s;
    q_ff.smp_flag && sample_store_req && counter_overflow_interrupt
      && !q_ff.ovf[0];
  endsequence

  ovf_status_set_a: assert property (
    wrap[0] && !q_ff.precise[0] |=> q_ff.ovf[0])
    else $error("overflow status not set on wrap");
  ovf_clear_a: assert property (
    clr[2] && !wrap[2] |=> !q_ff.ovf[2])
    else $error("overflow clear ignored");
  fixed_irq_a: assert property (
    wrap[2] && q_ff.fix_ctl[`PECU_FXC_IRQ] |=> counter_overflow_interrupt)
    else $error("fixed overflow interrupt missing");
  global_stop_a: assert property (
    !q_ff.glob_en[2] && !wr[2] |=> $stable(cnt[2]))
    else $error("counter moved while globally off");
  halt_hold_a: assert property (
    halt && !wr[3] |=> $stable(cnt[3]))
    else $error("core cycles counted while halted");
  vm_exit_hold_a: assert property (
    vm_exit && !wr[2] |=> $stable(cnt[2]))
    else $error("instruction counted on vm exit");
  precise_path_a: assert property (
    precise_wrap_s |=> precise_effect_s)
    else $error("precise overflow handling wrong");
  sign_extend_a: assert property (
    wr[0] |=> cnt[0][47:32] == {16{$past(msr_wdata[31])}})
    else $error("counter write not sign extended");
  enum_fixed_a: assert property (
    msr_rd && msr_addr == `PECU_A_ENUM_FX |=>
      msr_rvalid && msr_rdata[12:0] == 13'h0603)
    else $error("fixed counter enumeration wrong");
  freeze_ctr_a: assert property (
    $past(q_ff.frz_ct) && $rose(counter_overflow_interrupt) |->
      q_ff.glob_en == '0)
    else $error("counters not frozen on interrupt");

endmodule : pecu_top
`default_nettype wire

// File: verification/pecu_partner.sv
// Model of the core side: event pulse sources, reference clock, irq sink.
// Assumes the bench asks for events one cycle ahead on ev_req.
`timescale 1ns/1ps
`default_nettype none

module pecu_partner (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [6:0] ev_req,
  input  wire logic       ref_go,
  input  wire logic       counter_overflow_interrupt,
  input  wire logic       sample_store_req,
  input  wire logic       branch_record_freeze,
  output logic            retire_last_uop,
  output logic            retire_fault,
  output logic            vm_exit,
  output logic            last_level_cache_ref,
  output logic            last_level_cache_miss,
  output logic            branch_retire,
  output logic            branch_mispredict,
  output logic            ref_tick,
  output logic      [7:0] irq_cnt,
  output logic      [7:0] smp_cnt,
  output logic      [7:0] brf_cnt
);
  // ****************************************
  // Event lines and reference clock
  // ****************************************
  logic [6:0] ev_ff;   // Registered event requests
  logic [3:0] half_ff; // Half periods still to run
  logic [1:0] div_ff;  // Four core cycles per half period
  assign {vm_exit, retire_fault, branch_mispredict, branch_retire,
          last_level_cache_miss, last_level_cache_ref,
          retire_last_uop} = ev_ff;

  // Reference clock stands low outside a burst of five periods
  always_ff @(posedge clk) begin
    if (reset) begin
      ev_ff    <= 7'h00;
      half_ff  <= 4'h0;
      div_ff   <= 2'h0;
      ref_tick <= 1'b0;
      irq_cnt  <= 8'h00;
      smp_cnt  <= 8'h00;
      brf_cnt  <= 8'h00;
    end else begin
      ev_ff   <= ev_req;
      irq_cnt <= irq_cnt + {7'h00, counter_overflow_interrupt};
      smp_cnt <= smp_cnt + {7'h00, sample_store_req};
      brf_cnt <= brf_cnt + {7'h00, branch_record_freeze};
      if (ref_go) begin
        half_ff <= 4'ha;
      end else if (half_ff != 4'h0) begin
        div_ff <= div_ff + 2'h1;
        if (div_ff == 2'h3) begin
          ref_tick <= ~ref_tick;
          half_ff  <= half_ff - 4'h1;
        end
      end
    end
  end
endmodule : pecu_partner
`default_nettype wire

// File: verification/test_perf_event_counter_unit.sv
// Self-checking bench of the counter unit with the core-side model.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "pecu_consts.svh"

module test_perf_event_counter_unit;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        msr_wr = 1'b0;
  logic        msr_rd = 1'b0;
  logic [11:0] msr_addr = 12'h000;
  logic [63:0] msr_wdata = 64'h0;
  logic [63:0] msr_rdata;
  logic        msr_rvalid;
  logic        cpl0 = 1'b1;
  logic [4:0]  stall = 5'h00;  // Clock-stopping conditions
  logic [6:0]  ev_req = 7'h00; // Event requests to the model
  logic        ref_go = 1'b0;
  wire logic   cstate_idle, halt, stop_clock_input;
  wire logic   thermal_throttle, freq_switch;
  logic        ref_tick, retire_last_uop, retire_fault, vm_exit;
  logic        last_level_cache_ref, last_level_cache_miss;
  logic        branch_retire, branch_mispredict;
  logic        counter_overflow_interrupt, sample_store_req;
  logic        branch_record_freeze;
  logic [7:0]  irq_cnt, smp_cnt, brf_cnt;
  int          n_errors = 0;
  int          check_count = 0;
  localparam logic [63:0] CLR_ALL = 64'hc000_0007_0000_0003;
  localparam logic [15:0] CODES [5] = '{`PECU_EV_INSTR, `PECU_EV_LLCREF,
    `PECU_EV_LLCMISS, `PECU_EV_BR, `PECU_EV_BRMISS};
  assign {freq_switch, thermal_throttle, stop_clock_input, halt,
          cstate_idle} = stall;

  always #4 clk = ~clk;

  pecu_top u_dut (.clk, .reset, .msr_wr, .msr_rd, .msr_addr, .msr_wdata,
    .msr_rdata, .msr_rvalid, .cpl0, .cstate_idle, .halt, .stop_clock_input,
    .thermal_throttle, .freq_switch, .ref_tick, .retire_last_uop,
    .retire_fault, .vm_exit, .last_level_cache_ref, .last_level_cache_miss,
    .branch_retire, .branch_mispredict, .counter_overflow_interrupt,
    .sample_store_req, .branch_record_freeze);
  pecu_partner u_core (.clk, .reset, .ev_req, .ref_go,
    .counter_overflow_interrupt, .sample_store_req, .branch_record_freeze,
    .retire_last_uop, .retire_fault, .vm_exit, .last_level_cache_ref,
    .last_level_cache_miss, .branch_retire, .branch_mispredict, .ref_tick,
    .irq_cnt, .smp_cnt, .brf_cnt);

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask : check
  // One write, effective at the next edge
  task automatic wreg(input logic [11:0] a, input logic [63:0] d);
    @(posedge clk);
    msr_wr    <= 1'b1;
    msr_addr  <= a;
    msr_wdata <= d;
    @(posedge clk);
    msr_wr <= 1'b0;
  endtask : wreg
  // Answer stands for the one cycle after the read edge
  task automatic rreg(input logic [11:0] a, output logic [63:0] d);
    @(posedge clk);
    msr_rd   <= 1'b1;
    msr_addr <= a;
    @(posedge clk);
    msr_rd <= 1'b0;
    #1;
    check(msr_rvalid, 1'b1);
    d = msr_rdata;
  endtask : rreg
  task automatic expect_reg(input logic [11:0] a, input logic [63:0] e);
    logic [63:0] d;
    rreg(a, d);
    check(d, e);
  endtask : expect_reg
  task automatic pulse(input logic [6:0] m, input int n);
    repeat (n) begin
      @(posedge clk);
      ev_req <= m;
      @(posedge clk);
      ev_req <= 7'h00;
    end
    repeat (3) @(posedge clk);
  endtask : pulse
  // Counter stopped before reload, overflow flags cleared after
  task automatic arm_gp(input logic [31:0] sel, input logic [63:0] v);
    wreg(`PECU_A_GP_SEL, 64'h0);
    wreg(`PECU_A_GP_CTR, v);
    wreg(`PECU_A_GP_SEL, {32'h0, sel});
    wreg(`PECU_A_GLB_EN, 64'h1);
    wreg(`PECU_A_GLB_CLR, CLR_ALL);
  endtask : arm_gp

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_enum;
    expect_reg(`PECU_A_ENUM_FX, 64'h603);
    expect_reg(`PECU_A_ENUM_EV, 64'h0);
    expect_reg(`PECU_A_GLB_ST, 64'h0);
    wreg(`PECU_A_ENUM_FX, 64'hffff_ffff_ffff_ffff);
    expect_reg(`PECU_A_ENUM_FX, 64'h603);
    expect_reg(12'h3ff, 64'h0);
  endtask : t_enum
  task automatic t_gp_events;
    for (int i = 0; i < 5; i++) begin
      arm_gp({16'h0043, CODES[i]}, 64'h0);
      pulse(7'h01 << i, 3);
      expect_reg(`PECU_A_GP_CTR, 64'h3);
    end
    arm_gp(32'h0003_00c0, 64'h0);
    pulse(7'h01, 2);
    expect_reg(`PECU_A_GP_CTR, 64'h0);
    arm_gp(32'h0043_00c0, 64'h0);
    pulse(7'h21, 2);
    pulse(7'h41, 2);
    pulse(7'h01, 1);
    expect_reg(`PECU_A_GP_CTR, 64'h1);
    wreg(`PECU_A_GLB_EN, 64'h0);
    pulse(7'h01, 2);
    expect_reg(`PECU_A_GP_CTR, 64'h1);
  endtask : t_gp_events
  task automatic t_fixed;
    logic [63:0] a, b;
    wreg(`PECU_A_FIX_CTL, 64'h331);
    wreg(`PECU_A_GLB_EN, 64'h7_0000_0000);
    @(posedge clk) cpl0 <= 1'b0;
    pulse(7'h01, 2);
    expect_reg(`PECU_A_FX_CTR, 64'h0);
    @(posedge clk) cpl0 <= 1'b1;
    pulse(7'h41, 1);
    pulse(7'h01, 2);
    expect_reg(`PECU_A_FX_CTR, 64'h2);
    @(posedge clk) ref_go <= 1'b1;
    @(posedge clk) ref_go <= 1'b0;
    repeat (60) @(posedge clk);
    expect_reg(`PECU_A_FX_CTR + 12'h2, 64'h5);
    for (int s = 0; s < 5; s++) begin
      @(posedge clk) stall <= 5'h01 << s;
      repeat (4) @(posedge clk);
      rreg(`PECU_A_FX_CTR + 12'h1, a);
      repeat (10) @(posedge clk);
      rreg(`PECU_A_FX_CTR + 12'h1, b);
      check(b, a);
      @(posedge clk) stall <= 5'h00;
      repeat (4) @(posedge clk);
    end
    rreg(`PECU_A_FX_CTR + 12'h1, a);
    repeat (10) @(posedge clk);
    rreg(`PECU_A_FX_CTR + 12'h1, b);
    check(b != a, 1'b1);
  endtask : t_fixed
  task automatic t_overflow;
    logic [7:0] i0, s0, f0;
    arm_gp(32'h0053_00c0, 64'hffff_ffff);
    expect_reg(`PECU_A_GP_CTR, 64'hffff_ffff_ffff);
    i0 = irq_cnt;
    pulse(7'h01, 1);
    expect_reg(`PECU_A_GLB_ST, 64'h1);
    check(irq_cnt, i0 + 8'h01);
    expect_reg(`PECU_A_GP_CTR, 64'h0);
    wreg(`PECU_A_GLB_CLR, 64'h1);
    expect_reg(`PECU_A_GLB_ST, 64'h0);
    wreg(`PECU_A_GLB_EN, 64'h0);
    expect_reg(`PECU_A_GLB_ST, 64'h8000_0000_0000_0000);
    wreg(`PECU_A_DBG, 64'h1800);
    wreg(`PECU_A_FIX_CTL, 64'h00b);
    wreg(`PECU_A_FX_CTR, 64'hffff_ffff_ffff);
    wreg(`PECU_A_GLB_EN, 64'h1_0000_0000);
    wreg(`PECU_A_GLB_CLR, CLR_ALL);
    i0 = irq_cnt;
    f0 = brf_cnt;
    pulse(7'h01, 1);
    expect_reg(`PECU_A_GLB_ST, 64'h1_0000_0000);
    check(irq_cnt, i0 + 8'h01);
    check(brf_cnt, f0 + 8'h01);
    expect_reg(`PECU_A_GLB_EN, 64'h0);
    wreg(`PECU_A_DBG, 64'h0);
    wreg(`PECU_A_PRECISE, 64'h1);
    arm_gp(32'h0053_00c0, 64'hffff_ffff);
    i0 = irq_cnt;
    s0 = smp_cnt;
    pulse(7'h01, 1);
    expect_reg(`PECU_A_GLB_ST, 64'h4000_0000_0000_0000);
    check(smp_cnt, s0 + 8'h01);
    check(irq_cnt, i0 + 8'h01);
  endtask : t_overflow

  // ****************************************
  // Sequence, verdict and watchdog
  // ****************************************
  task automatic conclude;
    if (n_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_enum();
    t_gp_events();
    t_fixed();
    t_overflow();
    conclude();
  end

  // Whole run takes well under a tenth of this
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    conclude();
  end
endmodule : test_perf_event_counter_unit
`default_nettype wire
